//--- rtl/two_wire_host_pkg.sv
// Purpose: Shared types and constants for the two-wire bus host controller.
// Assumes: System clock of 50 MHz.
// Notes: Bus phase lengths are derived from times in nanoseconds.
`default_nettype none
package two_wire_host_pkg;
  localparam int CLK_MHZ = 50;
  localparam int CNT_W = 9;
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int ADDR_W = 7;
  localparam int SYNC_W = 4;
  // Standard and fast rates: high phase minima and the full bit period.
  localparam int T_HIGH_STD_NS = 4800;
  localparam int T_HIGH_FAST_NS = 600;
  localparam int T_LOW_STD_MIN_NS = 4800;
  localparam int T_LOW_FAST_MIN_NS = 1300;
  localparam int T_PERIOD_STD_NS = 10000;
  localparam int T_PERIOD_FAST_NS = 2500;
  // The low phase fills the period so the rate never exceeds the limit.
  localparam int T_LOW_STD_NS = T_PERIOD_STD_NS - T_HIGH_STD_NS;
  localparam int T_LOW_FAST_NS = T_PERIOD_FAST_NS - T_HIGH_FAST_NS;
  localparam logic [CNT_W-1:0] HI_STD_CYC =
    CNT_W'((T_HIGH_STD_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] HI_FAST_CYC =
    CNT_W'((T_HIGH_FAST_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] LO_STD_CYC =
    CNT_W'((T_LOW_STD_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] LO_FAST_CYC =
    CNT_W'((T_LOW_FAST_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] CNT_RESET = 9'h000;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [1:0] LAST_READ_IDX = 2'h2;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 4'hf;

  typedef enum logic [1:0] {
    OP_WRITE,
    OP_PTR,
    OP_READ,
    OP_AUTO
  } op_type;

  typedef enum {
    S_IDLE,
    S_SETUP,
    S_START,
    S_LOW,
    S_HIGH,
    S_RESTART,
    S_STOP_LOW,
    S_STOP_HIGH,
    S_STOP_FREE
  } state_type;

  typedef struct packed {
    op_type op;
    logic [ADDR_W-1:0] addr;
    logic [BYTE_W-1:0] ptr;
    logic [BYTE_W-1:0] d0;
    logic [BYTE_W-1:0] d1;
    logic four;
    logic fast;
  } cmd_type;

  localparam cmd_type CMD_RESET = '0;
endpackage : two_wire_host_pkg
`default_nettype wire

//--- rtl/byte_fifo.sv
// Purpose: Small first-in first-out buffer with valid/ready on both sides.
// Assumes: Single clock domain.
// Notes: Full and empty follow the fill count exactly.
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [PW:0] fill_q, fill_d;
  logic do_wr, do_rd;

  assign in_ready = (fill_q != (PW+1)'(DEPTH));
  assign out_valid = (fill_q != '0);
  assign out_data = mem_q[rd_q];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;

  always_comb begin
    wr_d = wr_q;
    rd_d = rd_q;
    fill_d = fill_q;
    if (do_wr) begin
      wr_d = (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + PW'(1);
    end
    if (do_rd) begin
      rd_d = (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + PW'(1);
    end
    if (do_wr && !do_rd) begin
      fill_d = fill_q + (PW+1)'(1);
    end else if (do_rd && !do_wr) begin
      fill_d = fill_q - (PW+1)'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      fill_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      fill_q <= fill_d;
    end
  end

  // Storage needs no reset; it is only read once written.
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule : byte_fifo
`default_nettype wire

//--- rtl/two_wire_host.sv
// Purpose: Two-wire bus master that reaches the device's slave port.
// Assumes: Open-drain pins resolved outside; pull-ups on both lines.
// Notes: Received bytes pass an 8-entry buffer; a full buffer stretches SCL.
//
// How it works
// - Both lines only pulled low or released; released reads high.
// - Start is SDA falling, stop SDA rising, both while SCL high.
// - SDA changes only while SCL low, except start and stop.
// - Every byte is eight bits followed by one acknowledge bit.
// - Bits go most significant first.
// - First byte is the 7-bit address then the direction bit.
// - Write: second byte is register pointer, then one or two data bytes (none for a pointer-only write).
// - Read: address byte then two data bytes from the slave.
// - Slave returns pointed register first, then pointer plus one.
// - Sender releases SDA on ack clock; receiver holds it low throughout.
// - Missing address ack leaves SDA high; master then stops.
// - In reads the direction turns after the address acknowledge.
// - Master does not acknowledge the final read byte, then stops.
// - Slave may hold SCL low between bytes; master waits for release.
`default_nettype none
module two_wire_host (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire two_wire_host_pkg::cmd_type cmd,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [7:0] rd_data,
  output logic done,
  output logic nack,
  input wire logic done_clr,
  input wire logic nack_clr,
  output logic busy,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic dev_irq_i,
  input wire logic dev_ready_i,
  output logic dev_irq,
  output logic dev_ready
);
  import two_wire_host_pkg::*;

  state_type state_q, state_d;
  cmd_type cmd_q, cmd_d;
  logic [CNT_W-1:0] cnt_q, cnt_d, lo_c, hi_c, half_c;
  logic [3:0] bit_q, bit_d;
  logic [1:0] idx_q, idx_d, last_idx;
  logic rd_ph_q, rd_ph_d, hi_seen_q, hi_seen_d;
  logic [BYTE_W-1:0] sh_q, sh_d;
  logic scl_oe_n_q, scl_oe_n_d, sda_oe_n_q, sda_oe_n_d;
  logic done_q, done_d, nack_q, nack_d;
  logic push, fifo_ready, sending, last_rx;
  logic [SYNC_W-1:0] s1_q, s2_q;
  logic scl_s, sda_s;

  // Pin inputs cross into the clock domain through two flip-flops.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= SYNC_RESET;
      s2_q <= SYNC_RESET;
    end else begin
      s1_q <= {dev_ready_i, dev_irq_i, sda_i, scl_i};
      s2_q <= s1_q;
    end
  end
  assign scl_s = s2_q[0];
  assign sda_s = s2_q[1];
  assign dev_irq = s2_q[2];
  assign dev_ready = s2_q[3];

  // Open drain: the output level is always low, only the enable moves.
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_n = scl_oe_n_q;
  assign sda_oe_n = sda_oe_n_q;
  assign done = done_q;
  assign nack = nack_q;
  assign busy = (state_q != S_IDLE);
  assign cmd_ready = (state_q == S_IDLE);

  // Phase lengths for the rate latched with the command.
  assign lo_c = cmd_q.fast ? LO_FAST_CYC : LO_STD_CYC;
  assign hi_c = cmd_q.fast ? HI_FAST_CYC : HI_STD_CYC;
  assign half_c = {1'b0, lo_c[CNT_W-1:1]};

  // Address byte is sent by the master even in the read phase.
  assign sending = !rd_ph_q || (idx_q == 2'h0);
  assign last_rx = rd_ph_q && (idx_q == LAST_READ_IDX);

  always_comb begin
    if (rd_ph_q) begin
      last_idx = LAST_READ_IDX;
    end else if (cmd_q.op == OP_PTR || cmd_q.op == OP_AUTO) begin
      last_idx = 2'h1;
    end else begin
      last_idx = cmd_q.four ? 2'h3 : 2'h2;
    end
  end

  function automatic logic [BYTE_W-1:0] tx_byte(
    input cmd_type c,
    input logic rd,
    input logic [1:0] i
  );
    logic [BYTE_W-1:0] b;
    b = '0;
    case (i)
      2'h0: b = {c.addr, rd};
      2'h1: b = c.ptr;
      2'h2: b = c.d0;
      2'h3: b = c.d1;
      default: b = '0;
    endcase
    return b;
  endfunction : tx_byte

  always_comb begin
    state_d = state_q;
    cmd_d = cmd_q;
    cnt_d = cnt_q;
    bit_d = bit_q;
    idx_d = idx_q;
    rd_ph_d = rd_ph_q;
    hi_seen_d = hi_seen_q;
    sh_d = sh_q;
    scl_oe_n_d = scl_oe_n_q;
    sda_oe_n_d = sda_oe_n_q;
    // A new event wins over a clear in the same cycle.
    done_d = done_q & ~done_clr;
    nack_d = nack_q & ~nack_clr;
    push = 1'b0;
    case (state_q)
      S_IDLE: begin
        scl_oe_n_d = 1'b1;
        sda_oe_n_d = 1'b1;
        if (cmd_valid) begin
          cmd_d = cmd;
          rd_ph_d = (cmd.op == OP_READ);
          idx_d = 2'h0;
          cnt_d = CNT_RESET;
          state_d = S_SETUP;
        end
      end
      S_SETUP: begin
        // Both lines released; wait until SCL really is high.
        scl_oe_n_d = 1'b1;
        if (!scl_s) begin
          cnt_d = CNT_RESET;
        end else if (cnt_q == hi_c - 9'h001) begin
          cnt_d = CNT_RESET;
          state_d = S_START;
        end else begin
          cnt_d = cnt_q + 9'h001;
        end
      end
      S_START: begin
        sda_oe_n_d = 1'b0;
        if (cnt_q == hi_c - 9'h001) begin
          cnt_d = CNT_RESET;
          bit_d = 4'h0;
          sh_d = tx_byte(cmd_q, rd_ph_q, idx_q);
          scl_oe_n_d = 1'b0;
          state_d = S_LOW;
        end else begin
          cnt_d = cnt_q + 9'h001;
        end
      end
      S_LOW: begin
        scl_oe_n_d = 1'b0;
        if (bit_q == 4'h0 && !sending && !fifo_ready) begin
          // No room for another byte: hold SCL low until one entry is read out.
          cnt_d = CNT_RESET;
        end else if (cnt_q == lo_c - 9'h001) begin
          cnt_d = CNT_RESET;
          hi_seen_d = 1'b0;
          scl_oe_n_d = 1'b1;
          state_d = S_HIGH;
        end else begin
          cnt_d = cnt_q + 9'h001;
        end
        // Data moves mid-way through the low phase, well clear of edges.
        if (cnt_q == half_c) begin
          if (bit_q != ACK_BIT) begin
            sda_oe_n_d = sending ? sh_q[BYTE_W-1] : 1'b1;
          end else if (sending) begin
            sda_oe_n_d = 1'b1;
          end else begin
            sda_oe_n_d = last_rx;
          end
        end
      end
      S_HIGH: begin
        scl_oe_n_d = 1'b1;
        if (scl_s) begin
          hi_seen_d = 1'b1;
          cnt_d = cnt_q + 9'h001;
        end
        // Ends at full high time, or early when another master pulls low.
        if ((hi_seen_q && !scl_s) ||
            (scl_s && cnt_q == hi_c - 9'h001)) begin
          cnt_d = CNT_RESET;
          hi_seen_d = 1'b0;
          scl_oe_n_d = 1'b0;
          state_d = S_LOW;
          if (bit_q != ACK_BIT) begin
            sh_d = {sh_q[BYTE_W-2:0], sda_s};
            bit_d = bit_q + 4'h1;
          end else if (sending && sda_s) begin
            nack_d = 1'b1;
            state_d = S_STOP_LOW;
          end else begin
            push = !sending;
            if (idx_q != last_idx) begin
              idx_d = idx_q + 2'h1;
              bit_d = 4'h0;
              sh_d = tx_byte(cmd_q, rd_ph_q, idx_q + 2'h1);
            end else if (cmd_q.op == OP_AUTO && !rd_ph_q) begin
              rd_ph_d = 1'b1;
              idx_d = 2'h0;
              state_d = S_RESTART;
            end else begin
              state_d = S_STOP_LOW;
            end
          end
        end
      end
      S_RESTART: begin
        scl_oe_n_d = 1'b0;
        if (cnt_q == half_c) begin
          sda_oe_n_d = 1'b1;
        end
        if (cnt_q == lo_c - 9'h001) begin
          cnt_d = CNT_RESET;
          scl_oe_n_d = 1'b1;
          state_d = S_SETUP;
        end else begin
          cnt_d = cnt_q + 9'h001;
        end
      end
      S_STOP_LOW: begin
        scl_oe_n_d = 1'b0;
        if (cnt_q == half_c) begin
          sda_oe_n_d = 1'b0;
        end
        if (cnt_q == lo_c - 9'h001) begin
          cnt_d = CNT_RESET;
          scl_oe_n_d = 1'b1;
          state_d = S_STOP_HIGH;
        end else begin
          cnt_d = cnt_q + 9'h001;
        end
      end
      S_STOP_HIGH: begin
        if (!scl_s) begin
          cnt_d = CNT_RESET;
        end else if (cnt_q == hi_c - 9'h001) begin
          cnt_d = CNT_RESET;
          sda_oe_n_d = 1'b1;
          state_d = S_STOP_FREE;
        end else begin
          cnt_d = cnt_q + 9'h001;
        end
      end
      S_STOP_FREE: begin
        // Bus free time before the next start may follow.
        if (cnt_q == hi_c - 9'h001) begin
          cnt_d = CNT_RESET;
          done_d = 1'b1;
          state_d = S_IDLE;
        end else begin
          cnt_d = cnt_q + 9'h001;
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      cmd_q <= CMD_RESET;
      cnt_q <= CNT_RESET;
      bit_q <= 4'h0;
      idx_q <= 2'h0;
      rd_ph_q <= 1'b0;
      hi_seen_q <= 1'b0;
      sh_q <= 8'h00;
      scl_oe_n_q <= 1'b1;
      sda_oe_n_q <= 1'b1;
      done_q <= 1'b0;
      nack_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cmd_q <= cmd_d;
      cnt_q <= cnt_d;
      bit_q <= bit_d;
      idx_q <= idx_d;
      rd_ph_q <= rd_ph_d;
      hi_seen_q <= hi_seen_d;
      sh_q <= sh_d;
      scl_oe_n_q <= scl_oe_n_d;
      sda_oe_n_q <= sda_oe_n_d;
      done_q <= done_d;
      nack_q <= nack_d;
    end
  end

  // Read bytes in order: pointed register first, then the next one.
  byte_fifo #(
    .WIDTH(BYTE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data(sh_q),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );
endmodule : two_wire_host
`default_nettype wire

//--- sim/two_wire_dev_model.sv
// Purpose: Behavioural model of the device's two-wire slave port.
// Assumes: Pull-ups on both lines; a drive_n output low pulls its line.
// Notes: Reads leave the pointer alone, so repeated reads return the same.
`default_nettype none
module two_wire_dev_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic hold,
  output logic scl_drive_n,
  output var logic sda_drive_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] regs [256];
  logic [7:0] ptr = 8'h00;
  logic [7:0] sh = 8'h00;
  logic [7:0] tx = 8'h00;
  logic active = 1'b0;
  logic me = 1'b0;
  logic rd = 1'b0;
  logic mack = 1'b1;
  int bitc = 0;
  int nb = 0;
  assign scl_drive_n = ~hold;
  initial begin
    sda_drive_n = 1'b1;
    for (int i = 0; i < 256; i++) regs[i] = ~8'(i);
  end
  // The delay keeps SDA changes clear of the falling SCL edge.
  task automatic drive(input logic v);
    sda_drive_n <= #100 v;
  endtask : drive
  always @(negedge sda) if (scl === 1'b1) begin
    active = 1'b1;
    bitc = 0;
    nb = 0;
  end
  always @(posedge sda) if (scl === 1'b1) active = 1'b0;
  always @(posedge scl) if (active) begin
    bitc++;
    if (bitc <= 8) sh = {sh[6:0], sda};
    else mack = sda;
  end
  always @(negedge scl) if (active) begin
    if (bitc == 8) begin
      if (nb == 0) begin
        me = sh[7:1] >= 7'h08 && sh[7:1] <= 7'h0b;
        rd = sh[0];
      end
      else if (!rd && me && nb == 1) ptr = sh;
      else if (!rd && me) regs[ptr + 8'(nb - 2)] = sh;
      drive(!(me && (nb == 0 || !rd)));
    end
    else if (bitc == 9) begin
      bitc = 0;
      nb++;
      if (rd && me && (nb == 1 || (nb == 2 && !mack))) begin
        tx = regs[ptr + 8'(nb - 1)];
        drive(tx[7]);
      end
      else drive(1'b1);
    end
    else if (rd && me && nb > 0) drive(tx[3'(7 - bitc)]);
  end
endmodule : two_wire_dev_model
`default_nettype wire

//--- sim/two_wire_host_chk.sv
// Purpose: Concurrent checks on the two-wire host's ports.
// Assumes: scl_i and sda_i carry the resolved wire levels.
// Notes: Phase minima are judged against the rate of the last command.
`default_nettype none
module two_wire_host_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire two_wire_host_pkg::cmd_type cmd,
  input wire logic done,
  input wire logic nack,
  input wire logic done_clr,
  input wire logic nack_clr,
  input wire logic busy,
  input wire logic scl_i,
  input wire logic scl_oe_n,
  input wire logic sda_oe_n,
  input wire logic dev_irq_i,
  input wire logic dev_ready_i,
  input wire logic dev_irq,
  input wire logic dev_ready
);
  import two_wire_host_pkg::*;
  localparam int LO_STD = 240;
  localparam int LO_FAST = 65;
  localparam int HI_STD = 240;
  localparam int HI_FAST = 30;
  logic fast_q, fast_d;
  logic [9:0] lo_q, lo_d, hi_q, hi_d;
  logic [1:0] up_q, up_d;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  always_comb begin
    fast_d = (cmd_valid && cmd_ready) ? cmd.fast : fast_q;
    lo_d = scl_i ? 10'h000 : lo_q + {9'h000, lo_q != 10'h3ff};
    hi_d = !scl_i ? 10'h000 : hi_q + {9'h000, hi_q != 10'h3ff};
    up_d = up_q + {1'b0, up_q != 2'h3};
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fast_q <= 1'b0;
      lo_q <= 10'h000;
      hi_q <= 10'h000;
      up_q <= 2'h0;
    end else begin
      fast_q <= fast_d;
      lo_q <= lo_d;
      hi_q <= hi_d;
      up_q <= up_d;
    end
  end
  sequence start_seq;
    $fell(sda_oe_n) && scl_i && scl_oe_n;
  endsequence
  sequence stop_seq;
    $rose(sda_oe_n) && scl_i && scl_oe_n;
  endsequence
  reset_idle_a: assert property ($rose(rst_n) |->
    scl_oe_n && sda_oe_n && cmd_ready && !busy && !done && !nack)
    else $error("host not idle after reset");
  start_hold_a: assert property (start_seq |-> (scl_oe_n && busy) [*8])
    else $error("start condition too short");
  stop_free_a: assert property (stop_seq |-> ##[20:300] (done && !busy))
    else $error("bus not freed after stop");
  low_min_a: assert property ($rose(scl_i) |->
    lo_q >= (fast_q ? LO_FAST : LO_STD)) else $error("scl low too short");
  high_min_a: assert property ($fell(scl_i) |->
    hi_q >= (fast_q ? HI_FAST : HI_STD)) else $error("scl high too short");
  stretch_wait_a: assert property (scl_oe_n && !scl_i &&
    $past(scl_oe_n && !scl_i) |-> $stable(sda_oe_n))
    else $error("host moved while scl held");
  done_hold_a: assert property (done && !done_clr |=> done)
    else $error("done lost before clear");
  nack_hold_a: assert property (nack && !nack_clr |=> nack)
    else $error("nack lost before clear");
  dev_pass_a: assert property (up_q == 2'h3 |-> dev_irq ==
    $past(dev_irq_i, 2) && dev_ready == $past(dev_ready_i, 2))
    else $error("device pin not passed through");
endmodule : two_wire_host_chk
bind two_wire_host two_wire_host_chk two_wire_host_chk_i (.clk, .rst_n,
  .cmd_valid, .cmd_ready, .cmd, .done, .nack, .done_clr, .nack_clr, .busy,
  .scl_i, .scl_oe_n, .sda_oe_n, .dev_irq_i, .dev_ready_i, .dev_irq,
  .dev_ready);
`default_nettype wire

//--- sim/two_wire_host_test.sv
// Purpose: Self-checking bench for the two-wire bus host controller.
// Assumes: Pull-ups on both lines; the device model answers at 08h-0bh.
// Notes: Most traffic runs at the fast rate to keep the run short.
`default_nettype none
module two_wire_host_test;
  timeunit 1ns;
  timeprecision 1ps;
  import two_wire_host_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  cmd_type cmd = CMD_RESET;
  logic rd_ready = 1'b0;
  logic done_clr = 1'b0;
  logic nack_clr = 1'b0;
  logic dev_irq_i = 1'b1;
  logic dev_ready_i = 1'b1;
  logic hold = 1'b0;
  logic cmd_ready, rd_valid, done, nack, busy, dev_irq, dev_ready;
  logic scl_oe_n, sda_oe_n, dev_scl_n, dev_sda_n, scl_o, sda_o;
  logic [7:0] rd_data;
  wire logic scl_w = scl_oe_n & dev_scl_n;
  wire logic sda_w = sda_oe_n & dev_sda_n;
  int errors = 0;
  int num_checks = 0;
  `define check_eq(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
    errors++; $display("unexpected %s: expected %h seen %h", nm, e, g); \
    end end
  always #10 clk = ~clk;
  two_wire_host two_wire_host_i (.clk, .rst_n, .cmd_valid, .cmd_ready, .cmd,
    .rd_valid, .rd_ready, .rd_data, .done, .nack, .done_clr, .nack_clr,
    .busy, .scl_i(scl_w), .scl_o, .scl_oe_n, .sda_i(sda_w), .sda_o,
    .sda_oe_n, .dev_irq_i, .dev_ready_i, .dev_irq, .dev_ready);
  two_wire_dev_model two_wire_dev_model_i (.scl(scl_w), .sda(sda_w), .hold,
    .scl_drive_n(dev_scl_n), .sda_drive_n(dev_sda_n));
  function automatic cmd_type mk(input op_type op, input logic [6:0] a,
      input logic [7:0] p, input logic [15:0] d, input logic [1:0] f);
    mk = '{op, a, p, d[15:8], d[7:0], f[1], f[0]};
  endfunction : mk
  task automatic report_and_stop;
    if (errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  task automatic offer(input cmd_type c);
    @(negedge clk);
    cmd = c;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    `check_eq("busy", 1'b1, busy)
  endtask : offer
  task automatic finish(input logic ok);
    for (int n = 0; n < 40000 && done !== 1'b1; n++) @(negedge clk);
    `check_eq("done", 1'b1, done)
    `check_eq("nack", !ok, nack)
    done_clr = 1'b1;
    nack_clr = 1'b1;
    @(negedge clk);
    done_clr = 1'b0;
    nack_clr = 1'b0;
    `check_eq("flags", 3'h0, {done, nack, busy})
  endtask : finish
  task automatic run(input cmd_type c, input logic ok);
    offer(c);
    finish(ok);
  endtask : run
  task automatic pop(input logic [7:0] e);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (rd_valid !== 1'b1 && n < 20000);
    `check_eq("rd_data", e, rd_data)
    rd_ready = 1'b1;
    @(negedge clk);
    rd_ready = 1'b0;
  endtask : pop
  task automatic t_reset;
    `check_eq("idle", 5'h1c, {scl_oe_n, sda_oe_n, cmd_ready, busy, done})
    `check_eq("empty", 2'h0, {nack, rd_valid})
    `check_eq("pin_level", 2'h0, {scl_o, sda_o})
  endtask : t_reset
  task automatic t_pins;
    dev_irq_i = 1'b0;
    repeat (3) @(negedge clk);
    `check_eq("dev_irq", 2'h1, {dev_irq, dev_ready})
    dev_irq_i = 1'b1;
    dev_ready_i = 1'b0;
    repeat (3) @(negedge clk);
    `check_eq("dev_ready", 2'h2, {dev_irq, dev_ready})
    dev_ready_i = 1'b1;
  endtask : t_pins
  task automatic t_xfer;
    run(mk(OP_WRITE, 7'h09, 8'h10, 16'h5ce1, 2'h2), 1'b1);
    run(mk(OP_WRITE, 7'h0b, 8'h12, 16'h9600, 2'h1), 1'b1);
    run(mk(OP_PTR, 7'h08, 8'h10, 16'h0000, 2'h1), 1'b1);
    run(mk(OP_READ, 7'h0a, 8'h00, 16'h0000, 2'h1), 1'b1);
    pop(8'h5c);
    pop(8'he1);
    run(mk(OP_AUTO, 7'h0b, 8'h11, 16'h0000, 2'h1), 1'b1);
    pop(8'he1);
    pop(8'h96);
  endtask : t_xfer
  task automatic t_nack;
    run(mk(OP_READ, 7'h07, 8'h00, 16'h0000, 2'h1), 1'b0);
    run(mk(OP_WRITE, 7'h0c, 8'h10, 16'h0000, 2'h1), 1'b0);
    `check_eq("rd_valid", 1'b0, rd_valid)
  endtask : t_nack
  task automatic t_stretch;
    offer(mk(OP_WRITE, 7'h08, 8'h20, 16'h3c00, 2'h1));
    repeat (10) @(negedge scl_w);
    @(negedge clk);
    hold = 1'b1;
    repeat (300) @(negedge clk);
    `check_eq("stretch", 2'h0, {scl_w, done})
    hold = 1'b0;
    finish(1'b1);
    run(mk(OP_AUTO, 7'h08, 8'h20, 16'h0000, 2'h1), 1'b1);
    pop(8'h3c);
    pop(8'hde);
  endtask : t_stretch
  task automatic t_fill;
    // Four reads fill the buffer; the fifth must wait with SCL held low.
    for (int n = 0; n < 4; n++)
      run(mk(OP_READ, 7'h09, 8'h00, 16'h0000, 2'h1), 1'b1);
    offer(mk(OP_READ, 7'h09, 8'h00, 16'h0000, 2'h1));
    repeat (4000) @(negedge clk);
    `check_eq("full_stall", 3'h2, {done, busy, scl_w})
    for (int n = 0; n < 5; n++) begin
      pop(8'h3c);
      pop(8'hde);
    end
    finish(1'b1);
  endtask : t_fill
  task automatic t_reset_mid;
    offer(mk(OP_WRITE, 7'h0a, 8'h30, 16'h0000, 2'h1));
    repeat (400) @(negedge clk);
    rst_n = 1'b0;
    @(negedge clk);
    `check_eq("abandon", 4'he, {scl_oe_n, sda_oe_n, cmd_ready, busy})
    rst_n = 1'b1;
    run(mk(OP_PTR, 7'h0a, 8'h10, 16'h0000, 2'h1), 1'b1);
  endtask : t_reset_mid
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    t_reset;
    t_pins;
    t_xfer;
    t_nack;
    t_stretch;
    t_fill;
    t_reset_mid;
    report_and_stop;
  end
  initial begin
    // About 95000 cycles: the full run needs roughly 75000.
    #1900000;
    errors++;
    report_and_stop;
  end
endmodule : two_wire_host_test
`default_nettype wire
